// [hdl/spm_pkg.sv]
// Purpose: Shared constants and types for the sleep power mode controller.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes:   Counts are small; regulator wait is a timing figure, not a pin.
package spm_pkg;

    // Clock period in ns
    localparam int CLK_PERIOD_NS   = 10;
    // Regulator start-up time in us, as printed
    localparam int REG_STARTUP_US  = 50;
    // Cycles to wait for regulators, rounded up
    localparam int REG_WAIT_CYC    = (REG_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Cycles in the core reset state; core_reset is also high through power-up
    localparam int CORE_RST_CYC    = 4;
    // Counter width covering the longest count
    localparam int CNT_W           = 13;

    // Deep sleep variant codes
    localparam logic [1:0] VAR_EMU  = 2'h0;
    localparam logic [1:0] VAR_ONE  = 2'h1;
    localparam logic [1:0] VAR_TWO  = 2'h2;

    // Reset values of outputs
    localparam logic RC_ON_RESET    = 1'b1;
    localparam logic REG_ON_RESET   = 1'b1;

    // Controller states, Gray coded from run through core reset
    typedef enum logic [2:0] {
        SPM_RUN      = 3'b000,
        SPM_PRE_DEEP = 3'b001,
        SPM_DEEP     = 3'b011,
        SPM_POWER_UP = 3'b010,
        SPM_CORE_RST = 3'b110,
        SPM_IDLE     = 3'b100,
        SPM_EMU      = 3'b101
    } spm_state_t;

endpackage

// [hdl/spm_sync.sv]
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs are levels, not pulses.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module spm_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;   // First stage, metastability catcher

    // Two stages in series
    always_ff @(posedge clk) begin
        if (rst) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// [hdl/spm_ctrl.sv]
// Purpose: Sequences the core between run, idle sleep and deep sleep variants.
// Assumes: Core signals share clk; debug requests and wake pins are asynchronous.
// Notes:   Clock is the always-on domain; it keeps running through deep sleep.
`timescale 1ns/1ps

// Contract
// - WAIT_FOR_INTERRUPT_INSTR without deep bit enters idle sleep
// - WAIT_FOR_INTERRUPT_INSTR with deep bit runs deep sleep
// - Pre-deep state waits for system request clear
// - Core reset cycle on power-up
// - RC oscillator runs in variant 1 default
// - Variant 2 stops timers unless crystal clocked
// - Variant 2 keeps non-timer wake sources
// - Variant 2 wake restarts RC oscillator
// - Debug connected forces emulated variant 0
// - System request blocks deep sleep entry
// - True deep sleep needs both requests clear
// - Either debug request rising wakes chip
// - Debug access stalled until chip ready
// - Regulators off during deep sleep
// - External regulator pin low in deep
// - Variant 0 keeps core, resets peripherals
// - Timer wakes in variant 1, and in variant 2 when crystal clocked
module spm_ctrl
    import spm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wait_for_interrupt_instr,
    input  wire logic       deep_sleep_request_bit,
    input  wire logic       rc_off_select,
    input  wire logic       timer_on_crystal,
    input  wire logic       irq_pending,
    input  wire logic       debug_system_powerup_request,
    input  wire logic       debug_connected_powerup_request,
    input  wire logic       io_wake_event,
    input  wire logic       timer_cmpa_wake,
    input  wire logic       timer_cmpb_wake,
    input  wire logic       timer_wrap_wake,
    input  wire logic       wake_core_write,
    output logic            core_run,
    output logic            core_power_on,
    output logic            core_reset,
    output logic            periph_reset,
    output logic            low_freq_rc_oscillator,
    output logic            timer_clock_enable,
    output logic            regulator_enable,
    output logic            ext_regulator_control_pin_o,
    output logic            ext_regulator_control_pin_oe_n,
    output logic            debug_stall,
    output logic [1:0]      sleep_variant,
    output spm_pkg::spm_state_t state_out
);
    import spm_pkg::*;

    spm_state_t       state;         // Current state
    spm_state_t       next_state;    // Next state
    logic [CNT_W-1:0] cnt;           // Power-up / reset timer
    logic [CNT_W-1:0] next_cnt;      // Next timer value
    logic [1:0]       var_q;         // Variant chosen on entry
    logic [1:0]       next_var;      // Next variant
    logic [3:0]       async_raw;     // Bundle of pin-side levels
    logic [3:0]       async_s;       // Synchronised bundle
    logic             dbg_sys;       // Synced system request
    logic             dbg_con;       // Synced connected request
    logic             io_wake;       // Synced io wake
    logic             tmr_any;       // Synced timer wakes, ored before sync
    logic [1:0]       dbg_prev;      // Last-cycle debug requests for edge find
    logic             dbg_rise;      // Any debug request just set
    logic             sel_emu;       // Emulated variant selected
    logic [1:0]       entry_var;     // Variant for a new deep request
    logic             deep_go;       // Deep entry allowed: system request clear
    logic             timer_wake_ok; // Timer may wake now
    logic             wake;          // Wake from true deep sleep
    logic             emu_wake;      // Wake from emulated sleep
    logic             cnt_done;      // Timer expired
    logic             tmr_raw;       // Timer wake sources combined pre-sync

    // Timer wakes are registered pulses from the same chip; combine then sync
    assign tmr_raw   = timer_cmpa_wake | timer_cmpb_wake | timer_wrap_wake;
    assign async_raw = {debug_system_powerup_request, debug_connected_powerup_request,
                        io_wake_event, tmr_raw};

    // Debug port and wake pins cross into this domain
    spm_sync #(.W(4)) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (async_raw),
        .sync_out (async_s)
    );

    assign dbg_sys = async_s[3];
    assign dbg_con = async_s[2];
    assign io_wake = async_s[1];
    assign tmr_any = async_s[0];

    // Rising edge of either debug request counts as a wake
    assign dbg_rise = (dbg_sys & ~dbg_prev[1]) | (dbg_con & ~dbg_prev[0]);

    // Debug connection outranks the oscillator-off choice
    assign sel_emu   = dbg_con;
    assign entry_var = sel_emu       ? VAR_EMU :
                       rc_off_select ? VAR_TWO : VAR_ONE;

    // Deep entry is refused while the system request is up
    assign deep_go = ~dbg_sys;

    // Timer wakes need the timer clock alive
    assign timer_wake_ok = (var_q == VAR_ONE) |
                           ((var_q == VAR_TWO) & timer_on_crystal);

    // Non-timer sources always wake; timer ones only when clocked
    assign wake = io_wake | dbg_rise | (tmr_any & timer_wake_ok);

    // Emulated sleep also listens to the core-wake write and interrupts
    assign emu_wake = wake | wake_core_write | irq_pending;

    assign cnt_done = (cnt == '0);

    // State and counter sequencing
    always_comb begin
        next_state = state;
        next_cnt   = (cnt == '0) ? cnt : cnt - CNT_W'(1);
        next_var   = var_q;
        unique case (state)
            SPM_RUN: begin
                if (wait_for_interrupt_instr & ~deep_sleep_request_bit) begin
                    next_state = SPM_IDLE;
                end else if (wait_for_interrupt_instr) begin
                    next_state = SPM_PRE_DEEP;
                end
            end
            SPM_IDLE: begin
                // Idle keeps power; any interrupt resumes
                if (irq_pending) begin
                    next_state = SPM_RUN;
                end
            end
            SPM_PRE_DEEP: begin
                // Nothing powers off until the system request is clear
                if (deep_go) begin
                    next_var   = entry_var;
                    next_state = (entry_var == VAR_EMU) ? SPM_EMU : SPM_DEEP;
                end
            end
            SPM_EMU: begin
                if (emu_wake) begin
                    next_state = SPM_RUN;
                end
            end
            SPM_DEEP: begin
                if (wake) begin
                    // Load one short: the cycle that reads zero is the last one
                    next_state = SPM_POWER_UP;
                    next_cnt   = CNT_W'(REG_WAIT_CYC - 1);
                end
            end
            SPM_POWER_UP: begin
                // Wait for regulators before releasing the core
                if (cnt_done) begin
                    next_state = SPM_CORE_RST;
                    next_cnt   = CNT_W'(CORE_RST_CYC - 1);
                end
            end
            SPM_CORE_RST: begin
                if (cnt_done) begin
                    next_state = SPM_RUN;
                    next_var   = VAR_ONE;
                end
            end
            default: begin
                // Unused codes recover to run
                next_state = SPM_RUN;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= SPM_RUN;
            cnt      <= '0;
            var_q    <= VAR_ONE;
            dbg_prev <= 2'h0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            var_q    <= next_var;
            dbg_prev <= {dbg_sys, dbg_con};
        end
    end

    // Output registers, decoded from the next state so they align with it
    always_ff @(posedge clk) begin
        if (rst) begin
            core_run               <= 1'b1;
            core_power_on          <= 1'b1;
            core_reset             <= 1'b0;
            periph_reset           <= 1'b0;
            low_freq_rc_oscillator <= RC_ON_RESET;
            timer_clock_enable     <= 1'b1;
            regulator_enable       <= REG_ON_RESET;
            debug_stall            <= 1'b0;
        end else begin
            core_run      <= (next_state == SPM_RUN);
            // Core domain dark only in true deep or while regulators rise
            core_power_on <= (next_state != SPM_DEEP) &
                             (next_state != SPM_POWER_UP);
            core_reset    <= (next_state == SPM_CORE_RST) |
                             (next_state == SPM_POWER_UP);
            // Emulated sleep holds peripherals only, core stays live
            periph_reset  <= (next_state == SPM_EMU);
            // Oscillator off only inside variant 2; any wake restarts it
            low_freq_rc_oscillator <= ~((next_state == SPM_DEEP) &
                                        (next_var == VAR_TWO));
            timer_clock_enable <= ~((next_state == SPM_DEEP) & (next_var == VAR_TWO) &
                                    ~timer_on_crystal);
            regulator_enable <= (next_state != SPM_DEEP);
            // Hold debug off while power or reset is still in progress
            debug_stall <= (dbg_sys | dbg_con) &
                           ((next_state == SPM_DEEP) | (next_state == SPM_POWER_UP) |
                            (next_state == SPM_CORE_RST));
        end
    end

    // Open-drain pin: drive low in deep, release otherwise
    assign ext_regulator_control_pin_o    = 1'b0;
    assign ext_regulator_control_pin_oe_n = ~(state == SPM_DEEP);

    assign sleep_variant = var_q;
    assign state_out     = state;
endmodule

// [tb/spm_dbg_model.sv]
// Purpose: Debugger stand-in that drives both power-up requests.
// Assumes: Bench calls tasks just after a rising clock edge.
// Notes:   Access waits out the stall instead of giving up early.
`timescale 1ns/1ps
module spm_dbg_model (
    input  wire logic clk,
    input  wire logic debug_stall,
    output logic      debug_system_powerup_request,
    output logic      debug_connected_powerup_request
);
    // Plain levels, as a connected debugger would hold them
    task automatic set(input logic s, input logic c);
        debug_system_powerup_request    = s;
        debug_connected_powerup_request = c;
    endtask
    // Memory access: raise the request, tolerate the hold-off, go idle
    task automatic access(output int waited);
        waited = 0;
        debug_system_powerup_request = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        while (debug_stall && waited < 6000) begin
            @(posedge clk);
            #1;
            waited++;
        end
        debug_system_powerup_request = 1'b0;
    endtask
endmodule

// [tb/spm_ctrl_chk.sv]
// Purpose: Port assertions for the sleep power mode controller.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Only design outputs are judged.
`timescale 1ns/1ps
module spm_ctrl_chk
    import spm_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                wait_for_interrupt_instr,
    input wire logic                deep_sleep_request_bit,
    input wire logic                irq_pending,
    input wire logic                core_run,
    input wire logic                core_power_on,
    input wire logic                core_reset,
    input wire logic                periph_reset,
    input wire logic                low_freq_rc_oscillator,
    input wire logic                regulator_enable,
    input wire logic                ext_regulator_control_pin_oe_n,
    input wire logic [1:0]          sleep_variant,
    input wire spm_pkg::spm_state_t state_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_IDLE_IN:
    assert property (state_out == SPM_RUN && wait_for_interrupt_instr && !deep_sleep_request_bit
        |=> state_out == SPM_IDLE && !core_run && core_power_on) else $error("no idle entry");
    AST_IDLE_OUT:
    assert property (state_out == SPM_IDLE && irq_pending |=> state_out == SPM_RUN && core_run)
        else $error("idle not left");
    AST_PRE_IN:
    assert property (state_out == SPM_RUN && wait_for_interrupt_instr && deep_sleep_request_bit
        |=> state_out == SPM_PRE_DEEP) else $error("no pre-deep entry");
    AST_PRE_HOLD:
    assert property (state_out == SPM_PRE_DEEP |-> core_power_on && regulator_enable
        && !core_reset && !periph_reset) else $error("power cut in pre-deep");
    AST_DEEP_OFF:
    assert property (state_out == SPM_DEEP |-> !core_power_on && !regulator_enable
        && !ext_regulator_control_pin_oe_n) else $error("supplies on in deep");
    AST_PIN_FREE:
    assert property (state_out != SPM_DEEP |-> ext_regulator_control_pin_oe_n)
        else $error("pin driven outside deep");
    AST_CORE_RST:
    assert property ($rose(state_out == SPM_CORE_RST) |-> (core_reset && !core_run)[*4]
        ##1 (core_run && !core_reset)) else $error("core reset cycle wrong");
    AST_EMU_KEEP:
    assert property (state_out == SPM_EMU |-> core_power_on && !core_reset && periph_reset
        && sleep_variant == VAR_EMU) else $error("emulated sleep wrong");
    AST_RC_VAR:
    assert property (low_freq_rc_oscillator == !(state_out == SPM_DEEP
        && sleep_variant == VAR_TWO)) else $error("rc enable wrong");
    cover property (state_out == SPM_IDLE);
    cover property (state_out == SPM_EMU);
    cover property (state_out == SPM_DEEP && sleep_variant == VAR_TWO);
endmodule
bind spm_ctrl spm_ctrl_chk i_chk (.clk, .rst, .wait_for_interrupt_instr,
    .deep_sleep_request_bit, .irq_pending, .core_run, .core_power_on, .core_reset,
    .periph_reset, .low_freq_rc_oscillator, .regulator_enable,
    .ext_regulator_control_pin_oe_n, .sleep_variant, .state_out);

// [tb/tb_sleep_power_mode_controller.sv]
// Purpose: Self-checking bench for the sleep power mode controller.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Power-up wait is a package constant, so deep wakes are slow.
`timescale 1ns/1ps
module tb_sleep_power_mode_controller;
    import spm_pkg::*;
    logic clk, rst, wait_for_interrupt_instr, deep_sleep_request_bit, rc_off_select;
    logic timer_on_crystal, irq_pending, io_wake_event, timer_cmpa_wake, timer_cmpb_wake;
    logic timer_wrap_wake, wake_core_write, debug_system_powerup_request, core_reset;
    logic debug_connected_powerup_request, core_run, core_power_on, periph_reset;
    logic low_freq_rc_oscillator, timer_clock_enable, regulator_enable, debug_stall;
    logic ext_regulator_control_pin_o, ext_regulator_control_pin_oe_n;
    logic [1:0] sleep_variant;
    spm_state_t state_out;
    int errors, samples_checked, w;
    // Row: deep bit, rc off, connected, wake by access, state, variant
    typedef struct packed {
        logic deep, rc_off, conn, acc;
        spm_state_t st;
        logic [1:0] vsel;
    } spm_row_t;
    spm_row_t r;
    spm_row_t rows [5] = '{'{1'b0, 1'b0, 1'b0, 1'b0, SPM_IDLE, VAR_ONE},
        '{1'b1, 1'b0, 1'b1, 1'b0, SPM_EMU, VAR_EMU}, '{1'b1, 1'b1, 1'b1, 1'b0, SPM_EMU, VAR_EMU},
        '{1'b1, 1'b0, 1'b0, 1'b1, SPM_DEEP, VAR_ONE}, '{1'b1, 1'b0, 1'b0, 1'b0, SPM_DEEP, VAR_ONE}};
    spm_ctrl i_dut (.*);
    spm_dbg_model i_dbg (.*);
    always #5 clk = ~clk;
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic enter(input logic d, input logic rc);
        deep_sleep_request_bit = d;
        rc_off_select = rc;
        wait_for_interrupt_instr = 1'b1;
        tick();
        wait_for_interrupt_instr = 1'b0;
        repeat (3) tick();
    endtask
    // Bounded wait: power-up plus core reset, with margin
    task automatic wait_run();
        for (int n = 0; n < 6000 && core_run !== 1'b1; n++) tick();
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (3) tick();
        check(state_out === SPM_RUN && core_run === 1'b1 && regulator_enable === 1'b1
            && ext_regulator_control_pin_oe_n === 1'b1 && sleep_variant === VAR_ONE
            && low_freq_rc_oscillator === 1'b1, "reset values");
        rst = 1'b0;
    endtask
    // Watchdog: 40000 cycles, over twice three power-up waits of about 5004 cycles
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
    initial begin
        {clk, wait_for_interrupt_instr, deep_sleep_request_bit, rc_off_select} = 4'h0;
        {timer_on_crystal, irq_pending, io_wake_event, timer_cmpa_wake} = 4'h0;
        {timer_cmpb_wake, timer_wrap_wake, wake_core_write} = 3'h0;
        i_dbg.set(1'b0, 1'b0);
        {errors, samples_checked} = '0;
        do_reset();
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            i_dbg.set(1'b0, r.conn);
            repeat (4) tick();
            enter(r.deep, r.rc_off);
            check(state_out === r.st, "entry state");
            check(!r.deep || sleep_variant === r.vsel, "variant");
            check(regulator_enable === (r.st != SPM_DEEP), "regulators");
            check(ext_regulator_control_pin_oe_n === (r.st != SPM_DEEP)
                && ext_regulator_control_pin_o === 1'b0, "pin");
            if (r.acc) begin
                i_dbg.access(w);
                check(w > 4000 && w < 6000, "stall");
            end else if (r.st == SPM_DEEP) begin
                timer_cmpa_wake = 1'b1;
                repeat (4) tick();
                timer_cmpa_wake = 1'b0;
            end else begin
                irq_pending = 1'b1;
                tick();
                irq_pending = 1'b0;
            end
            wait_run();
            check(core_run === 1'b1 && core_power_on === 1'b1, "wake");
        end
        i_dbg.set(1'b1, 1'b0);
        repeat (4) tick();
        enter(1'b1, 1'b0);
        repeat (6) tick();
        check(state_out === SPM_PRE_DEEP && core_power_on === 1'b1, "held");
        i_dbg.set(1'b0, 1'b0);
        repeat (4) tick();
        check(state_out === SPM_DEEP, "deep after release");
        do_reset();
        enter(1'b1, 1'b1);
        timer_cmpa_wake = 1'b1;
        repeat (6) tick();
        check(state_out === SPM_DEEP && timer_clock_enable === 1'b0, "timer");
        {timer_cmpa_wake, io_wake_event} = 2'h1;
        repeat (4) tick();
        io_wake_event = 1'b0;
        wait_run();
        check(core_run === 1'b1 && low_freq_rc_oscillator === 1'b1, "io wake");
        print_verdict();
    end
endmodule
